// >>> pkg/conv_ctrl_pkg.sv
// register map, field layout, encodings and timing counts of the converter control block
// assumes a 32-bit classic wishbone slave port; each register index sits at byte address 4*index
package conv_ctrl_pkg;

	// ------------------------------------------------------------------
	// register indices and byte address width
	// ------------------------------------------------------------------
	localparam logic [7:0]  IDX_RESULT_LOW   = 8'h78;
	localparam logic [7:0]  IDX_RESULT_HIGH  = 8'h79;
	localparam logic [7:0]  IDX_CTRL_STATUS  = 8'h7a;
	localparam logic [7:0]  IDX_TRIG_SELECT  = 8'h7b;
	localparam logic [7:0]  IDX_REF_CHAN     = 8'h7c;
	localparam int          ADR_W            = 10;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int          REF_SEL_HI       = 7;
	localparam int          REF_SEL_LO       = 6;
	localparam int          LEFT_ADJ_BIT     = 5;
	localparam int          CHAN_HI          = 3;
	localparam int          CHAN_LO          = 0;
	localparam int          ENABLE_BIT       = 7;
	localparam int          START_BIT        = 6;
	localparam int          AUTO_TRIG_BIT    = 5;
	localparam int          DONE_FLAG_BIT    = 4;
	localparam int          IRQ_EN_BIT       = 3;
	localparam int          DIV_HI           = 2;
	localparam int          DIV_LO           = 0;
	localparam int          TRIG_HI          = 2;
	localparam int          TRIG_LO          = 0;

	// ------------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------------
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam logic [1:0]  REF_EXT_PIN      = 2'h0;
	localparam logic [1:0]  REF_SUPPLY       = 2'h1;
	localparam logic [1:0]  REF_INTERNAL     = 2'h3;
	localparam logic [3:0]  CHAN_LAST_INPUT  = 4'h7;
	localparam logic [3:0]  CHAN_BANDGAP     = 4'he;
	localparam logic [3:0]  CHAN_GROUND      = 4'hf;
	localparam int          NUM_INPUTS       = 8;
	localparam logic [2:0]  TRIG_FREE_RUN    = 3'h0;
	localparam logic [2:0]  DIV_MIN_SHIFT    = 3'h1;
	localparam int          RESULT_W         = 10;

	// ------------------------------------------------------------------
	// conversion lengths in converter clock cycles
	// ------------------------------------------------------------------
	localparam logic [4:0]  FIRST_CONV_CYC   = 5'd25;
	localparam logic [4:0]  NORMAL_CONV_CYC  = 5'd13;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} conv_state_t;

endpackage

// >>> rtl/conv_ctrl.sv
// control and status registers of a 10-bit converter: bus slave, prescaler, conversion sequencer
// assumes the analog core samples on o_conv_start and holds i_conversion_result valid when a
// conversion ends; trigger sources and global interrupt enable are synchronous to i_core_clk
`timescale 1ns/100ps

module conv_ctrl
	import conv_ctrl_pkg::*;
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rstn,
	input  wire logic                  i_wb_cyc,
	input  wire logic                  i_wb_stb,
	input  wire logic                  i_wb_we,
	input  wire logic [ADR_W-1:0]      i_wb_adr,
	input  wire logic [3:0]            i_wb_sel,
	input  wire logic [31:0]           i_wb_dat,
	output logic      [31:0]           o_wb_dat,
	output logic                       o_wb_ack,
	input  wire logic [RESULT_W-1:0]   i_conversion_result,
	input  wire logic [7:0]            i_trigger_sources,
	input  wire logic                  i_global_irq_enable,
	input  wire logic                  i_irq_vector_ack,
	output logic                       o_converter_enable,
	output logic                       o_converter_clk,
	output logic                       o_conv_start,
	output logic                       o_conv_busy,
	output logic      [1:0]            o_reference_select,
	output logic      [3:0]            o_input_channel_select,
	output logic      [2:0]            o_ref_route,
	output logic      [NUM_INPUTS-1:0] o_input_route,
	output logic                       o_bandgap_route,
	output logic                       o_ground_route,
	output logic                       o_conv_done_irq
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		conv_state_t              state;
		logic                     wb_ack;
		logic [7:0]               rd_data;
		logic [1:0]               reference_select;
		logic                     left_adjust_result;
		logic [3:0]               input_channel_select;
		logic                     converter_enable;
		logic                     auto_trigger_enable;
		logic                     conversion_done_flag;
		logic                     conversion_done_irq_enable;
		logic [2:0]               clock_divider_select;
		logic [2:0]               trigger_source_select;
		logic [1:0]               act_ref;
		logic [3:0]               act_chan;
		logic [2:0]               ref_route;
		logic [NUM_INPUTS-1:0]    input_route;
		logic                     bandgap_route;
		logic                     ground_route;
		logic                     initialized;
		logic [6:0]               presc_cnt;
		logic                     conv_clk;
		logic [4:0]               conv_cnt;
		logic                     start_pulse;
		logic [RESULT_W-1:0]      conversion_result;
		logic                     lock;
		logic                     trig_prev;
		logic                     irq;
	} conv_st_t;

	localparam conv_st_t ST_RESET = '{state: ST_IDLE, default: '0};

	conv_st_t    st_r;
	conv_st_t    st_nxt;
	logic        take;
	logic        wr;
	logic        rd;
	logic [7:0]  idx;
	logic [7:0]  wdat;
	logic        start_req;
	logic        flag_clr;
	logic        trig_now;
	logic        trig_edge;
	logic        free_run;
	logic        tick;
	logic        begin_conv;
	logic        done_evt;
	logic [2:0]  shift;
	logic [6:0]  period_m1;
	logic [2:0]  clk_bit;
	logic [4:0]  last_cnt;
	logic [7:0]  rd_mux;

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt     = st_r;
		st_nxt.wb_ack      = 1'b0;
		st_nxt.start_pulse = 1'b0;
		start_req  = 1'b0;
		flag_clr   = 1'b0;
		done_evt   = 1'b0;
		begin_conv = 1'b0;
		idx        = i_wb_adr[ADR_W-1:2];
		wdat       = i_wb_dat[7:0];
		take       = i_wb_cyc & i_wb_stb & ~st_r.wb_ack;
		wr         = take & i_wb_we & i_wb_sel[0];
		rd         = take & ~i_wb_we;

		// read path: alignment follows the live bit, not the one at conversion time
		if (idx == IDX_RESULT_LOW) begin
			rd_mux = st_r.left_adjust_result ? {st_r.conversion_result[1:0], 6'h00}
			                                 : st_r.conversion_result[7:0];
		end else if (idx == IDX_RESULT_HIGH) begin
			rd_mux = st_r.left_adjust_result ? st_r.conversion_result[9:2]
			                                 : {6'h00, st_r.conversion_result[9:8]};
		end else if (idx == IDX_CTRL_STATUS) begin
			rd_mux = {st_r.converter_enable, (st_r.state == ST_BUSY), st_r.auto_trigger_enable,
			          st_r.conversion_done_flag, st_r.conversion_done_irq_enable, st_r.clock_divider_select};
		end else if (idx == IDX_TRIG_SELECT) begin
			rd_mux = {5'h00, st_r.trigger_source_select};
		end else if (idx == IDX_REF_CHAN) begin
			rd_mux = {st_r.reference_select, st_r.left_adjust_result, 1'b0,
			          st_r.input_channel_select};
		end else begin
			rd_mux = 8'h00;
		end
		st_nxt.wb_ack  = take;
		st_nxt.rd_data = rd ? rd_mux : 8'h00;

		// low byte read freezes the result pair until the high byte is read
		if (rd && idx == IDX_RESULT_LOW) begin
			st_nxt.lock = 1'b1;
		end else if (rd && idx == IDX_RESULT_HIGH) begin
			st_nxt.lock = 1'b0;
		end

		// write path
		if (wr && idx == IDX_REF_CHAN) begin
			st_nxt.reference_select     = wdat[REF_SEL_HI:REF_SEL_LO];
			st_nxt.left_adjust_result   = wdat[LEFT_ADJ_BIT];
			st_nxt.input_channel_select = wdat[CHAN_HI:CHAN_LO];
		end else if (wr && idx == IDX_CTRL_STATUS) begin
			st_nxt.converter_enable           = wdat[ENABLE_BIT];
			st_nxt.auto_trigger_enable        = wdat[AUTO_TRIG_BIT];
			st_nxt.conversion_done_irq_enable = wdat[IRQ_EN_BIT];
			st_nxt.clock_divider_select       = wdat[DIV_HI:DIV_LO];
			start_req = wdat[START_BIT];
			flag_clr  = wdat[DONE_FLAG_BIT];
		end else if (wr && idx == IDX_TRIG_SELECT) begin
			st_nxt.trigger_source_select = wdat[TRIG_HI:TRIG_LO];
		end

		// trigger edge of the selected source; source zero is held low so selecting it makes no edge
		trig_now  = (st_r.trigger_source_select == TRIG_FREE_RUN) ? 1'b0
		            : i_trigger_sources[st_r.trigger_source_select];
		st_nxt.trig_prev = trig_now;
		trig_edge = st_r.auto_trigger_enable & trig_now & ~st_r.trig_prev;
		free_run  = st_r.auto_trigger_enable && (st_r.trigger_source_select == TRIG_FREE_RUN);

		// prescaler: period is 2^shift system cycles, codes 0 and 1 both give 2
		shift     = (st_r.clock_divider_select < 3'h2) ? DIV_MIN_SHIFT : st_r.clock_divider_select;
		period_m1 = 7'((8'h01 << shift) - 8'h01);
		clk_bit   = shift - 3'h1;
		tick      = st_r.converter_enable && (st_r.presc_cnt == period_m1);
		if (!st_nxt.converter_enable) begin
			st_nxt.presc_cnt = 7'h00;
			st_nxt.conv_clk  = 1'b0;
		end else begin
			st_nxt.presc_cnt = tick ? 7'h00 : 7'(st_r.presc_cnt + 7'h01);
			st_nxt.conv_clk  = st_nxt.presc_cnt[clk_bit];
		end

		// conversion sequencer
		last_cnt   = st_r.initialized ? 5'(NORMAL_CONV_CYC - 5'd1) : 5'(FIRST_CONV_CYC - 5'd1);
		begin_conv = st_nxt.converter_enable && (start_req || trig_edge);
		case (st_r.state)
			ST_IDLE: begin
				st_nxt.act_ref  = st_nxt.reference_select;
				st_nxt.act_chan = st_nxt.input_channel_select;
				if (begin_conv) begin
					st_nxt.state       = ST_BUSY;
					st_nxt.conv_cnt    = 5'd0;
					st_nxt.start_pulse = 1'b1;
				end
			end
			ST_BUSY: begin
				if (!st_nxt.converter_enable) begin
					st_nxt.state = ST_IDLE;
				end else if (tick && st_r.conv_cnt == last_cnt) begin
					done_evt           = 1'b1;
					st_nxt.initialized = 1'b1;
					// a low byte read taken at this very edge must block the update as well
					if (!st_nxt.lock) begin
						st_nxt.conversion_result = i_conversion_result;
					end
					st_nxt.act_ref  = st_nxt.reference_select;
					st_nxt.act_chan = st_nxt.input_channel_select;
					if (free_run) begin
						st_nxt.conv_cnt    = 5'd0;
						st_nxt.start_pulse = 1'b1;
					end else begin
						st_nxt.state = ST_IDLE;
					end
				end else if (tick) begin
					st_nxt.conv_cnt = 5'(st_r.conv_cnt + 5'd1);
				end
			end
			default: begin
				st_nxt.state = ST_IDLE;
			end
		endcase
		if (!st_nxt.converter_enable) begin
			st_nxt.initialized = 1'b0;
		end

		// done flag: a completion in the same cycle as a clear keeps the flag set
		if (done_evt) begin
			st_nxt.conversion_done_flag = 1'b1;
		end else if (flag_clr || i_irq_vector_ack) begin
			st_nxt.conversion_done_flag = 1'b0;
		end
		st_nxt.irq = st_nxt.conversion_done_flag & st_nxt.conversion_done_irq_enable
		             & i_global_irq_enable;

		// analog routing decode of the applied selections
		st_nxt.ref_route[0] = (st_nxt.act_ref == REF_EXT_PIN);
		st_nxt.ref_route[1] = (st_nxt.act_ref == REF_SUPPLY);
		st_nxt.ref_route[2] = (st_nxt.act_ref == REF_INTERNAL);
		for (int k = 0; k < NUM_INPUTS; k++) begin
			st_nxt.input_route[k] = (st_nxt.act_chan == 4'(k));
		end
		st_nxt.bandgap_route = (st_nxt.act_chan == CHAN_BANDGAP);
		st_nxt.ground_route  = (st_nxt.act_chan == CHAN_GROUND);
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r <= ST_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign o_wb_ack               = st_r.wb_ack;
	assign o_wb_dat               = {24'h000000, st_r.rd_data};
	assign o_converter_enable     = st_r.converter_enable;
	assign o_converter_clk        = st_r.conv_clk;
	assign o_conv_start           = st_r.start_pulse;
	assign o_conv_busy            = (st_r.state == ST_BUSY);
	assign o_reference_select     = st_r.act_ref;
	assign o_input_channel_select = st_r.act_chan;
	assign o_ref_route            = st_r.ref_route;
	assign o_input_route          = st_r.input_route;
	assign o_bandgap_route        = st_r.bandgap_route;
	assign o_ground_route         = st_r.ground_route;
	assign o_conv_done_irq        = st_r.irq;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);

	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held for more than one cycle");
	a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("request not acknowledged in one cycle");
	a_unused_bit_zero: assert property (rd && idx == IDX_REF_CHAN |=> o_wb_dat[4] == 1'b0)
		else $error("unused select bit read as one");
	a_start_reads_busy: assert property (rd && idx == IDX_CTRL_STATUS
		|=> o_wb_dat[6] == $past(st_r.state == ST_BUSY))
		else $error("start bit does not show conversion in progress");
	a_off_aborts: assert property (!st_r.converter_enable |-> st_r.state == ST_IDLE && !o_conv_busy)
		else $error("conversion running while disabled");
	a_conv_length: assert property (done_evt
		|-> st_r.conv_cnt == (st_r.initialized ? 5'd12 : 5'd24))
		else $error("conversion length wrong");
	a_done_sets_flag: assert property (done_evt |=> st_r.conversion_done_flag
		&& (free_run || !o_conv_busy))
		else $error("completion did not set flag and clear busy together");
	a_flag_clear: assert property (st_r.conversion_done_flag && i_irq_vector_ack && !done_evt
		|=> !st_r.conversion_done_flag)
		else $error("vector did not clear done flag");
	a_irq_gating: assert property (o_conv_done_irq |-> st_r.conversion_done_flag
		&& st_r.conversion_done_irq_enable && $past(i_global_irq_enable))
		else $error("interrupt without all enables");
	a_lock_holds: assert property (st_nxt.lock |=> $stable(st_r.conversion_result))
		else $error("result changed while locked");
	a_select_held: assert property (st_r.state == ST_BUSY && st_nxt.state == ST_BUSY && !done_evt
		|=> $stable(o_reference_select) && $stable(o_input_channel_select))
		else $error("selection changed during conversion");
	a_trigger_starts: assert property (trig_edge && st_nxt.converter_enable
		&& st_r.state == ST_IDLE |=> o_conv_start && o_conv_busy)
		else $error("trigger edge did not start a conversion");

	// register view, analog routing and converter clock gating
	a_right_align: assert property (rd && idx == IDX_RESULT_LOW && !st_r.left_adjust_result
		|=> o_wb_dat[7:0] == $past(st_r.conversion_result[7:0]))
		else $error("right aligned low byte wrong");
	a_left_live: assert property (rd && idx == IDX_RESULT_HIGH && st_r.left_adjust_result
		|=> o_wb_dat[7:0] == $past(st_r.conversion_result[9:2]))
		else $error("left aligned high byte wrong");
	a_enable_reg: assert property (wr && idx == IDX_CTRL_STATUS
		|=> o_converter_enable == $past(wdat[ENABLE_BIT]))
		else $error("enable bit not taken from write");
	a_ref_decode: assert property ($past(i_rstn) |-> o_ref_route ==
		{o_reference_select == REF_INTERNAL, o_reference_select == REF_SUPPLY, o_reference_select == REF_EXT_PIN})
		else $error("reference routing does not match applied code");
	a_chan_decode: assert property ($past(i_rstn) |-> $onehot0(o_input_route)
		&& (o_input_route != 8'h00) == (o_input_channel_select <= CHAN_LAST_INPUT)
		&& o_bandgap_route == (o_input_channel_select == CHAN_BANDGAP)
		&& o_ground_route == (o_input_channel_select == CHAN_GROUND))
		else $error("channel routing does not match applied code");
	a_clk_idle_off: assert property (!o_converter_enable |-> !o_converter_clk)
		else $error("converter clock runs while disabled");

	// conversion sequencing and completion
	a_start_single: assert property (o_conv_start |=> !o_conv_start)
		else $error("start pulse longer than one cycle");
	a_start_zero_noop: assert property (wr && idx == IDX_CTRL_STATUS && !wdat[START_BIT]
		&& !trig_edge && st_r.state == ST_IDLE |=> !o_conv_busy)
		else $error("writing zero to start began a conversion");
	a_busy_refuses: assert property (st_r.state == ST_BUSY && start_req && !done_evt
		|=> !o_conv_start)
		else $error("start accepted while converting");
	a_free_restart: assert property (done_evt && free_run |=> o_conv_start && o_conv_busy)
		else $error("free running did not restart");
	a_done_result: assert property (done_evt && !st_nxt.lock
		|=> st_r.conversion_result == $past(i_conversion_result))
		else $error("result not captured at completion");
	a_flag_write_clear: assert property (wr && idx == IDX_CTRL_STATUS && wdat[DONE_FLAG_BIT]
		&& !done_evt |=> !st_r.conversion_done_flag)
		else $error("writing one did not clear done flag");
	a_irq_follows: assert property (st_r.conversion_done_flag && st_r.conversion_done_irq_enable
		&& i_global_irq_enable && !(wr && idx == IDX_CTRL_STATUS) && !i_irq_vector_ack
		|=> o_conv_done_irq)
		else $error("interrupt missing with all enables set");

	// ------------------------------------------------------------------
	// coverage of the main scenarios
	// ------------------------------------------------------------------
	c_first_conv: cover property (done_evt && !st_r.initialized);
	c_free_run: cover property (done_evt && free_run);
	c_locked_drop: cover property (done_evt && st_r.lock);
	c_irq: cover property (o_conv_done_irq);
	c_abort: cover property (st_r.state == ST_BUSY && !st_nxt.converter_enable);

endmodule // conv_ctrl

// >>> verification/analog_core_model.sv
// analog sampling core model: answers each start pulse with a code that names what was sampled
// assumes start is a one-cycle pulse on the system clock and the result is held until the next start
`timescale 1ns/100ps
module analog_core_model (
	input  wire logic       i_clk,
	input  wire logic       i_start,
	input  wire logic [1:0] i_ref,
	input  wire logic [3:0] i_chan,
	output logic      [9:0] o_result
);
	logic [3:0] seq_r;

	initial begin
		seq_r = 4'h0;
		o_result = 10'h000;
	end

	// the code carries the applied reference and channel, so a late mux change shows in the result
	always @(posedge i_clk) begin
		if (i_start) begin
			seq_r <= seq_r + 4'h1;
			o_result <= {i_ref, i_chan, seq_r + 4'h1};
		end
	end
endmodule // analog_core_model

// >>> verification/conv_ctrl_test.sv
// self-checking bench for conv_ctrl: register access over wishbone, conversions, alignment, lock
// assumes the analog core model answers every start pulse; sel enables only the low byte lane
`timescale 1ns/100ps
module conv_ctrl_test;
	import conv_ctrl_pkg::*;
	logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, gie = 1'b0, vack = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h00000000;
	logic [7:0]  trig = 8'h00;
	logic [31:0] rdat;
	logic        ack, en, cclk, cstart, busy, bg, gnd, irq;
	logic [1:0]  refsel;
	logic [3:0]  chan;
	logic [2:0]  refr;
	logic [7:0]  inr;
	logic [9:0]  res;
	int          n_errors = 0;
	int          tests_run = 0;

	always #25 clk = ~clk;

	conv_ctrl DUT (.i_core_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_conversion_result(res), .i_trigger_sources(trig), .i_global_irq_enable(gie),
		.i_irq_vector_ack(vack), .o_converter_enable(en), .o_converter_clk(cclk), .o_conv_start(cstart),
		.o_conv_busy(busy), .o_reference_select(refsel), .o_input_channel_select(chan), .o_ref_route(refr),
		.o_input_route(inr), .o_bandgap_route(bg), .o_ground_route(gnd), .o_conv_done_irq(irq));

	analog_core_model CORE (.i_clk(clk), .i_start(cstart), .i_ref(refsel), .i_chan(chan), .o_result(res));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// values are read before the edge's updates land, i.e. as sampled at that edge
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= {idx, 2'b00};
		wdat <= {24'h000000, d};
		@(posedge clk);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		q = rdat[7:0];
		if (n >= 20) check(32'h0, 32'h1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		sel <= 4'h0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		bus(1'b0, idx, 8'h00, q);
		check({24'h0, q}, {24'h0, exp});
	endtask

	// counts cycles with busy high; bounded so a stuck converter cannot hang the run
	task automatic wait_idle(output int c);
		c = 1;
		while (busy === 1'b1 && c < 20000) begin
			@(posedge clk);
			c++;
		end
	endtask

	task automatic span(input int c, input int n, input int d);
		check({31'h0, (c > (n - 1) * d) && (c <= n * d + 2)}, 32'h1);
	endtask

	function automatic logic [7:0] lo_b(input logic [9:0] r, input logic left);
		return left ? {r[1:0], 6'h00} : r[7:0];
	endfunction

	function automatic logic [7:0] hi_b(input logic [9:0] r, input logic left);
		return left ? r[9:2] : {6'h00, r[9:8]};
	endfunction

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin : watchdog
		repeat (60000) @(posedge clk);
		n_errors++;
		end_of_test();
	end

	// ------------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------------
	initial begin : main
		logic [7:0] idxs [5];
		logic [9:0] r1;
		logic       p;
		int i, c, d, k;
		idxs = '{8'h78, 8'h79, 8'h7a, 8'h7c, 8'h7d};
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 5; i++) rdc(idxs[i], 8'h00);
		$display("test reset values done");
		for (i = 0; i < 16; i++) begin
			wr(8'h7c, {i[1:0], 2'b01, i[3:0]});
			rdc(8'h7c, {i[1:0], 2'b00, i[3:0]});
			check(refr, (i[1:0] == 2'd0) ? 3'b001 : (i[1:0] == 2'd1) ? 3'b010 : (i[1:0] == 2'd3) ? 3'b100 : 3'b000);
			check({gnd, bg, inr}, {i == 15, i == 14, (i < 8) ? (8'h01 << i) : 8'h00});
		end
		wr(8'h7c, 8'h00);
		$display("test mux decode done");
		for (i = 0; i < 8; i++) begin
			d = (i < 2) ? 2 : (1 << i);
			wr(8'h7a, 8'hc0 | i[7:0]);
			wait_idle(c);
			span(c, 25, d);
			rdc(8'h7a, 8'h90 | i[7:0]);
			repeat (3) @(posedge clk);
			check(busy, 1'b0);
			check(en, 1'b1);
			p = cclk;
			k = 0;
			repeat (2 * d) begin
				@(posedge clk);
				k += (cclk && !p);
				p = cclk;
			end
			check(k, 2);
			wr(8'h7a, 8'hd0 | i[7:0]);
			wait_idle(c);
			span(c, 13, d);
			wr(8'h7a, 8'h10);
			rdc(8'h7a, 8'h00);
			check({en, cclk}, 2'b00);
		end
		$display("test prescaler and timing done");
		wr(8'h7c, 8'h45);
		wr(8'h7a, 8'hc0);
		wait_idle(c);
		r1 = res;
		rdc(8'h78, lo_b(r1, 1'b0));
		wr(8'h7c, 8'h65);
		rdc(8'h79, hi_b(r1, 1'b1));
		rdc(8'h78, lo_b(r1, 1'b1));
		wr(8'h7a, 8'hd0);
		wr(8'h7c, 8'he3);
		check({refsel, chan}, {2'h1, 4'h5});
		wait_idle(c);
		check({refsel, chan}, {2'h3, 4'h3});
		rdc(8'h79, hi_b(r1, 1'b1));
		wr(8'h7a, 8'hd0);
		wait_idle(c);
		r1 = res;
		check(r1[9:4], 6'h33);
		rdc(8'h78, lo_b(r1, 1'b1));
		rdc(8'h79, hi_b(r1, 1'b1));
		$display("test result alignment and lock done");
		wr(8'h7a, 8'h88);
		repeat (3) @(posedge clk);
		check(irq, 1'b0);
		gie <= 1'b1;
		repeat (3) @(posedge clk);
		check(irq, 1'b1);
		rdc(8'h7a, 8'h98);
		vack <= 1'b1;
		@(posedge clk);
		vack <= 1'b0;
		repeat (3) @(posedge clk);
		check(irq, 1'b0);
		wr(8'h7a, 8'hc8);
		wait_idle(c);
		repeat (2) @(posedge clk);
		check(irq, 1'b1);
		wr(8'h7a, 8'h98);
		rdc(8'h7a, 8'h88);
		$display("test done flag and interrupt done");
		wr(8'h7a, 8'hc0);
		repeat (10) @(posedge clk);
		wr(8'h7a, 8'h00);
		repeat (2) @(posedge clk);
		check(busy, 1'b0);
		rdc(8'h7a, 8'h00);
		wr(8'h7a, 8'hc0);
		wait_idle(c);
		span(c, 25, 2);
		$display("test abort done");
		wr(8'h7b, 8'h03);
		wr(8'h7a, 8'ha0);
		trig <= 8'h08;
		repeat (3) @(posedge clk);
		check(busy, 1'b1);
		wait_idle(c);
		wr(8'h7b, 8'h00);
		repeat (4) @(posedge clk);
		check(busy, 1'b0);
		trig <= 8'h00;
		wr(8'h7a, 8'he0);
		c = 0;
		for (i = 0; i < 70; i++) begin
			@(posedge clk);
			c += cstart;
		end
		check({31'h0, c >= 2 && busy === 1'b1}, 32'h1);
		wr(8'h7a, 8'h00);
		$display("test auto trigger done");
		end_of_test();
	end
endmodule // conv_ctrl_test
